// *** acs_pkg.sv ***
// Purpose: shared constants for the converter sequencer
// Assumes: 8-bit register port, word index addressing
// Notes:   offsets and reset values live here only
package acs_pkg;

  localparam int          ACS_AW          = 5;
  localparam int          ACS_DW          = 8;
  localparam int          ACS_RES_W       = 12;
  localparam int          ACS_CH_W        = 4;
  localparam int          ACS_SLOTS       = 2;

  // =========================================================
  // register offsets
  localparam logic [4:0]  OFS_ONESHOT_SEL = 5'h00;
  localparam logic [4:0]  OFS_CONV_CTRL1  = 5'h01;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h02;
  localparam logic [4:0]  OFS_IRQ_FLAGS   = 5'h03;
  localparam logic [4:0]  OFS_OS_RES_HI   = 5'h04;
  localparam logic [4:0]  OFS_OS_RES_LO   = 5'h05;
  localparam logic [4:0]  OFS_PER_SEL     = 5'h06;
  localparam logic [4:0]  OFS_PER_CTRL    = 5'h07;
  localparam logic [4:0]  OFS_POFF_DLY    = 5'h08;
  localparam logic [4:0]  OFS_STATUS      = 5'h09;
  // per slot block: base + 4*slot
  localparam logic [4:0]  OFS_SLOT_BASE   = 5'h10;
  localparam logic [1:0]  SLOT_LIM_HI     = 2'h0;
  localparam logic [1:0]  SLOT_LIM_LO     = 2'h1;
  localparam logic [1:0]  SLOT_RES_HI     = 2'h2;
  localparam logic [1:0]  SLOT_RES_LO     = 2'h3;

  // =========================================================
  // field positions
  localparam int          BIT_OS_ENABLE   = 7;
  localparam int          BIT_OS_START    = 4;
  localparam int          BIT_FORCE_ON    = 0;
  localparam int          BIT_IRQ_DONE    = 0;
  localparam int          BIT_IRQ_SLOT0   = 1;
  localparam int          BIT_LIM_POL     = 7;
  localparam int          BIT_PER_EN0     = 0;
  localparam int          BIT_POFF_EN0    = 2;
  localparam int          POS_RATE        = 4;
  localparam int          RATE_W          = 4;

  // =========================================================
  // reset values
  localparam logic [7:0]  RST_IRQ_MASK    = 8'h03;
  localparam logic [7:0]  RST_POFF_DLY    = 8'h10;
  localparam logic [7:0]  RST_ZERO        = 8'h00;

  // =========================================================
  // timing: one rate step and one poweroff delay step, in ns
  localparam int          CLK_NS          = 10;
  localparam int          RATE_STEP_NS    = 10000;
  localparam int          RATE_STEP_CYC   = RATE_STEP_NS / CLK_NS;
  localparam int          POFF_STEP_NS    = 10000;
  localparam int          POFF_STEP_CYC   = POFF_STEP_NS / CLK_NS;

  typedef enum logic [3:0] {
    ACS_IDLE  = 4'b0001,
    ACS_POWER = 4'b0010,
    ACS_CONV  = 4'b0100,
    ACS_DONE  = 4'b1000
  } acs_state_t;

endpackage : acs_pkg

// *** acs_slot.sv ***
// Purpose: one periodic slot: rate timer, threshold compare, result
// Assumes: result strobe comes from the shared sequencer
// Notes:   request stays high until the sequencer serves it or enable drops
`timescale 1ns/100ps
module acs_slot #(
  parameter int RES_W  = 12,
  parameter int RATE_W = 4,
  parameter int STEP   = 1000
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              enable,
  input  wire logic [RATE_W-1:0] rate,
  input  wire logic [RES_W-1:0]  limit,
  input  wire logic              polarity,
  input  wire logic              served,
  input  wire logic [RES_W-1:0]  sample,
  output logic                   request,
  output logic [RES_W-1:0]       result,
  output logic                   crossed
);
  import acs_pkg::*;

  initial begin
    if (STEP < 1 || RES_W < 1) $error("acs_slot: bad parameters");
  end

  logic [31:0]       step_cnt;
  logic [RATE_W:0]   period_cnt;
  wire  logic        step_tick  = (step_cnt == 32'(STEP - 1));
  wire  logic        period_end = step_tick && (period_cnt >= {1'b0, rate});
  // polarity 1: above limit, 0: below limit
  wire  logic        over       = sample > limit;
  wire  logic        under      = sample < limit;
  wire  logic        hit        = polarity ? over : under;

  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      step_cnt   <= '0;
      period_cnt <= '0;
      request    <= 1'b0;
    end else begin
      step_cnt <= step_tick ? '0 : step_cnt + 32'd1;
      if (step_tick) begin
        period_cnt <= period_end ? '0 : period_cnt + 1'b1;
      end
      if (served) begin
        request <= 1'b0;
      end else if (period_end) begin
        request <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result  <= '0;
      crossed <= 1'b0;
    end else begin
      crossed <= served && enable && hit;
      if (served) begin
        result <= sample;
      end
    end
  end

endmodule : acs_slot

// *** acs_seq.sv ***
// Function
// - a one-shot conversion converts the channel held in the one-shot channel field.
// - the converter is powered only on demand unless force-on keeps it on.
// - the one-shot done event has its own mask bit in the third mask register.
// - a finished one-shot conversion sets its done flag and raises the interrupt.
// - the 12-bit one-shot result reads as high bits [3:0] joined with low bits [7:0].
// - periodic conversion uses the slot channel and repeats at the programmed rate.
// - each slot compares its result against a 12-bit threshold in two registers.
// - a polarity bit selects firing above or below the threshold.
// - a per-slot poweroff enable makes a crossing also request shutdown.
// - a slot converts only while enabled and its event is maskable.
// - a threshold crossing sets the slot flag and raises the interrupt.
// - each slot's latest result is readable from its own register pair.
// - with poweroff on, shutdown follows the delay unless the flag is cleared first.
// - a second slot repeats every slot feature independently; here both slots share the rate field, the crossing flag and its mask bit.
//
// Purpose: sequencer and register file for the converter control block
// Assumes: converter core returns done with data; flags clear by writing one
// Notes:   irq and shutdown outputs are registered
`timescale 1ns/100ps
module acs_seq #(
  parameter int POFF_STEP = acs_pkg::POFF_STEP_CYC,
  parameter int RATE_STEP = acs_pkg::RATE_STEP_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic [acs_pkg::ACS_AW-1:0]    addr,
  input  wire logic [acs_pkg::ACS_DW-1:0]    wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [acs_pkg::ACS_DW-1:0]    rdata,
  output logic                               conv_power,
  output logic                               conv_start,
  output logic      [acs_pkg::ACS_CH_W-1:0]  conv_channel,
  input  wire logic                          conv_done,
  input  wire logic [acs_pkg::ACS_RES_W-1:0] conv_data,
  output logic                               irq,
  output logic                               poweroff_req,
  output logic      [acs_pkg::ACS_DW-1:0]    converter_control_one
);
  import acs_pkg::*;

  initial begin
    if (POFF_STEP < 1 || RATE_STEP < 1) $error("acs_seq: bad step counts");
  end

  // ==========================================================
  // register storage
  logic [7:0]           oneshot_select_reg;
  logic [7:0]           third_irq_mask;
  logic [1:0]           third_irq_flags;
  logic [7:0]           periodic_select_reg;
  logic [7:0]           periodic_control_reg;
  logic [7:0]           poweroff_delay;
  logic [ACS_RES_W-1:0] oneshot_result;
  logic [ACS_RES_W-1:0] limit     [ACS_SLOTS];
  logic [ACS_SLOTS-1:0] polarity;
  logic                 oneshot_pending;
  logic [ACS_SLOTS-1:0] served;
  logic [ACS_SLOTS-1:0] request;
  logic [ACS_SLOTS-1:0] crossed;
  logic [ACS_RES_W-1:0] slot_res  [ACS_SLOTS];
  logic [1:0]           owner;
  acs_state_t           state;
  acs_state_t           next_state;
  logic [31:0]          poff_cnt;
  logic                 poff_armed;

  // ==========================================================
  // decode
  wire logic       wr_os_sel  = wr && addr == OFS_ONESHOT_SEL;
  wire logic       wr_ctrl1   = wr && addr == OFS_CONV_CTRL1;
  wire logic       wr_mask    = wr && addr == OFS_IRQ_MASK;
  wire logic       wr_flags   = wr && addr == OFS_IRQ_FLAGS;
  wire logic       wr_per_sel = wr && addr == OFS_PER_SEL;
  wire logic       wr_per_ctl = wr && addr == OFS_PER_CTRL;
  wire logic       wr_poff    = wr && addr == OFS_POFF_DLY;
  wire logic       slot_area  = addr[4];
  wire logic       slot_idx   = addr[2];
  wire logic [1:0] slot_reg   = addr[1:0];
  wire logic       wr_lim_hi  = wr && slot_area && addr[3] == 1'b0 && slot_reg == SLOT_LIM_HI;
  wire logic       wr_lim_lo  = wr && slot_area && addr[3] == 1'b0 && slot_reg == SLOT_LIM_LO;
  wire logic       os_enable  = oneshot_select_reg[BIT_OS_ENABLE];
  wire logic       start_req  = wr_os_sel && wdata[BIT_OS_ENABLE] && wdata[BIT_OS_START];
  wire logic [1:0] clr_flags  = wr_flags ? wdata[1:0] : 2'b00;
  // both slots share the crossing flag, done flag sits in bit 0
  wire logic [1:0] set_flags  = {|crossed, state == ACS_DONE && owner == 2'd0};
  wire logic       force_on   = converter_control_one[BIT_FORCE_ON];
  wire logic [1:0] poff_en    = periodic_control_reg[BIT_POFF_EN0 +: 2];
  wire logic [1:0] poff_hit   = crossed & poff_en;
  wire logic [1:0] per_en     = periodic_control_reg[BIT_PER_EN0 +: 2];
  wire logic [RATE_W-1:0] rate = periodic_control_reg[POS_RATE +: RATE_W];
  wire logic [7:0] slot_rd    = slot_reg == SLOT_LIM_HI ? {polarity[slot_idx], 3'h0,
                                                           limit[slot_idx][11:8]} :
                                slot_reg == SLOT_LIM_LO ? limit[slot_idx][7:0] :
                                slot_reg == SLOT_RES_HI ? {4'h0, slot_res[slot_idx][11:8]} :
                                                          slot_res[slot_idx][7:0];
  wire logic [7:0] rd_mux     =
      addr == OFS_ONESHOT_SEL ? oneshot_select_reg :
      addr == OFS_CONV_CTRL1  ? converter_control_one :
      addr == OFS_IRQ_MASK    ? third_irq_mask :
      addr == OFS_IRQ_FLAGS   ? {6'h00, third_irq_flags} :
      addr == OFS_OS_RES_HI   ? {4'h0, oneshot_result[11:8]} :
      addr == OFS_OS_RES_LO   ? oneshot_result[7:0] :
      addr == OFS_PER_SEL     ? periodic_select_reg :
      addr == OFS_PER_CTRL    ? periodic_control_reg :
      addr == OFS_POFF_DLY    ? poweroff_delay :
      addr == OFS_STATUS      ? {3'h0, poff_armed, state} :
      (slot_area && !addr[3]) ? slot_rd : RST_ZERO;

  // ==========================================================
  // register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      oneshot_select_reg    <= RST_ZERO;
      converter_control_one <= RST_ZERO;
      third_irq_mask        <= RST_IRQ_MASK;
      periodic_select_reg   <= RST_ZERO;
      periodic_control_reg  <= RST_ZERO;
      poweroff_delay        <= RST_POFF_DLY;
    end else begin
      if (wr_os_sel) begin
        oneshot_select_reg <= wdata & ~(8'h01 << BIT_OS_START);
      end
      if (wr_ctrl1) begin
        converter_control_one <= wdata;
      end
      if (wr_mask) begin
        third_irq_mask <= wdata;
      end
      if (wr_per_sel) begin
        periodic_select_reg <= wdata;
      end
      if (wr_per_ctl) begin
        periodic_control_reg <= wdata;
      end
      if (wr_poff) begin
        poweroff_delay <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      limit[0] <= '0;
      limit[1] <= '0;
      polarity <= '0;
    end else begin
      if (wr_lim_hi) begin
        limit[slot_idx][11:8] <= wdata[3:0];
        polarity[slot_idx]    <= wdata[BIT_LIM_POL];
      end
      if (wr_lim_lo) begin
        limit[slot_idx][7:0] <= wdata;
      end
    end
  end

  // ==========================================================
  // flags: set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (srst) begin
      third_irq_flags <= 2'b00;
      irq             <= 1'b0;
      rdata           <= RST_ZERO;
    end else begin
      third_irq_flags <= (third_irq_flags & ~clr_flags) | set_flags;
      irq             <= |(third_irq_flags & ~third_irq_mask[1:0]);
      rdata           <= rd ? rd_mux : RST_ZERO;
    end
  end

  // ==========================================================
  // shared converter sequencing
  always_comb begin
    next_state = state;
    case (state)
      ACS_IDLE:  next_state = (oneshot_pending || |request) ? ACS_POWER : ACS_IDLE;
      ACS_POWER: next_state = ACS_CONV;
      ACS_CONV:  next_state = conv_done ? ACS_DONE : ACS_CONV;
      ACS_DONE:  next_state = ACS_IDLE;
      default:   next_state = ACS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state           <= ACS_IDLE;
      owner           <= 2'd0;
      oneshot_pending <= 1'b0;
      conv_start      <= 1'b0;
      conv_channel    <= '0;
      conv_power      <= 1'b0;
      oneshot_result  <= '0;
    end else begin
      state      <= next_state;
      conv_start <= state == ACS_POWER;
      conv_power <= force_on || next_state != ACS_IDLE;
      if (start_req) begin
        oneshot_pending <= 1'b1;
      end else if (state == ACS_IDLE && oneshot_pending) begin
        oneshot_pending <= 1'b0;
      end
      if (state == ACS_IDLE) begin
        if (oneshot_pending) begin
          owner        <= 2'd0;
          conv_channel <= oneshot_select_reg[ACS_CH_W-1:0];
        end else if (request[0]) begin
          owner        <= 2'd1;
          conv_channel <= periodic_select_reg[ACS_CH_W-1:0];
        end else if (request[1]) begin
          owner        <= 2'd2;
          conv_channel <= periodic_select_reg[7:4];
        end
      end
      if (state == ACS_CONV && conv_done && owner == 2'd0) begin
        oneshot_result <= conv_data;
      end
    end
  end

  wire logic done_now = state == ACS_CONV && conv_done;
  assign served[0] = done_now && owner == 2'd1;
  assign served[1] = done_now && owner == 2'd2;

  // ==========================================================
  // periodic slots
  for (genvar s = 0; s < ACS_SLOTS; s++) begin : g_slot
    acs_slot #(
      .RES_W  (ACS_RES_W),
      .RATE_W (RATE_W),
      .STEP   (RATE_STEP)
    ) u_slot (
      .clk      (clk),
      .srst     (srst),
      .enable   (per_en[s]),
      .rate     (rate),
      .limit    (limit[s]),
      .polarity (polarity[s]),
      .served   (served[s]),
      .sample   (conv_data),
      .request  (request[s]),
      .result   (slot_res[s]),
      .crossed  (crossed[s])
    );
  end

  // ==========================================================
  // delay runs from the first crossing, cleared slot flag cancels it
  wire logic poff_flag = third_irq_flags[BIT_IRQ_SLOT0];
  wire logic [31:0] poff_limit = 32'(poweroff_delay) * 32'(POFF_STEP);

  always_ff @(posedge clk) begin
    if (srst) begin
      poff_armed   <= 1'b0;
      poff_cnt     <= '0;
      poweroff_req <= 1'b0;
    end else begin
      if (|poff_hit && !poff_armed) begin
        poff_armed <= 1'b1;
        poff_cnt   <= '0;
      end else if (poff_armed && !poff_flag && !(|poff_hit)) begin
        poff_armed <= 1'b0;
      end else if (poff_armed && !poweroff_req) begin
        poff_cnt <= poff_cnt + 32'd1;
        if (poff_cnt + 32'd1 >= poff_limit) begin
          poweroff_req <= 1'b1;
        end
      end
    end
  end

endmodule : acs_seq

// *** acs_seq_props.sv ***
// Purpose: port checker for the converter sequencer
// Assumes: one clock, synchronous active high reset
// Notes:   bound from the bench top file
`timescale 1ns/100ps
module acs_seq_props #(
  parameter int POFF_STEP = 2,
  parameter int RATE_STEP = 2
) (
  input wire logic                          clk,
  input wire logic                          srst,
  input wire logic [acs_pkg::ACS_AW-1:0]    addr,
  input wire logic [acs_pkg::ACS_DW-1:0]    wdata,
  input wire logic                          wr,
  input wire logic                          rd,
  input wire logic [acs_pkg::ACS_DW-1:0]    rdata,
  input wire logic                          conv_power,
  input wire logic                          conv_start,
  input wire logic [acs_pkg::ACS_CH_W-1:0]  conv_channel,
  input wire logic                          conv_done,
  input wire logic [acs_pkg::ACS_RES_W-1:0] conv_data,
  input wire logic                          irq,
  input wire logic                          poweroff_req,
  input wire logic [acs_pkg::ACS_DW-1:0]    converter_control_one
);
  import acs_pkg::*;
  logic       mask_set;
  logic       poff_seen;
  logic [3:0] os_ch;
  wire        os_go = wr && addr == OFS_ONESHOT_SEL && wdata[BIT_OS_ENABLE] && wdata[BIT_OS_START];

  // =========================================================
  // helper state
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_set  <= 1'b0;
      poff_seen <= 1'b0;
    end else begin
      if (wr && addr == OFS_IRQ_MASK && wdata[1:0] != 2'b11) mask_set <= 1'b1;
      if (wr && addr == OFS_PER_CTRL && wdata[3:2] != 2'b00) poff_seen <= 1'b1;
    end
    if (os_go) os_ch <= wdata[3:0];
  end

  // =========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_RST_CLEAR: assert property ($past(srst) |-> !(conv_power | conv_start | irq | poweroff_req)
    && rdata == 8'h00 && converter_control_one == 8'h00) else $error("outputs not clear");
  AST_RD_ONLY: assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray read data");
  AST_UNMAPPED: assert property (rd && (addr inside {[5'h0a:5'h0f], [5'h18:5'h1f]})
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  AST_START_RD0: assert property (rd && addr == OFS_ONESHOT_SEL |=> !rdata[BIT_OS_START])
    else $error("start field reads one");
  AST_ONE_START: assert property (conv_start |=> !conv_start until conv_done)
    else $error("second start before done");
  AST_POWERED: assert property (conv_start |-> conv_power)
    else $error("start without power");
  AST_FORCE_ON: assert property (converter_control_one[BIT_FORCE_ON] |-> ##[0:1] conv_power)
    else $error("force on ignored");
  AST_OS_LAUNCH: assert property (os_go && !conv_power && !converter_control_one[BIT_FORCE_ON]
    |-> ##[2:4] (conv_start && conv_channel == os_ch))
    else $error("oneshot launch wrong");
  AST_POFF_GATE: assert property (!poff_seen |-> !poweroff_req)
    else $error("poweroff without enable");
  AST_POFF_STICKY: assert property (poweroff_req |=> poweroff_req)
    else $error("poweroff request dropped");
  AST_IRQ_MASKED: assert property (!mask_set |-> !irq)
    else $error("irq while masked");
endmodule : acs_seq_props

// *** acs_seq_tb.sv ***
// Purpose: self-checking bench for the converter sequencer
// Assumes: short rate and poweroff steps of 2 cycles
// Notes:   bench stands in for the converter core
`timescale 1ns/100ps
module acs_seq_tb;
  import acs_pkg::*;
  logic        clk, srst, wr, rd, conv_done, conv_power, conv_start, irq, poweroff_req;
  logic [4:0]  addr;
  logic [7:0]  wdata, rdata, converter_control_one, d;
  logic [3:0]  conv_channel, last_ch, ch, ch0, ch1;
  logic [11:0] conv_data, lim;
  logic [11:0] ch_val [16];
  logic [2:0]  lat;
  logic [31:0] seed, r;
  int          fail_count, checked, starts, i, n;
  // short step counts, busy cycles of one converter pass with margin
  localparam int STEP     = 2;
  localparam int CONV_CYC = 12;

  acs_seq #(.POFF_STEP(STEP), .RATE_STEP(STEP)) dut (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_power(conv_power),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_data(conv_data), .irq(irq), .poweroff_req(poweroff_req),
    .converter_control_one(converter_control_one));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // =========================================================
  // converter core stand-in, data toggles outside done
  always @(posedge clk) begin
    if (srst) begin
      conv_done <= 1'b0;
      conv_data <= 12'h000;
      lat       <= 3'd0;
      starts    <= 0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        lat <= 3'd4;
        starts <= starts + 1;
        last_ch <= conv_channel;
      end else if (lat != 3'd0) begin
        lat <= lat - 3'd1;
        if (lat == 3'd1) begin
          conv_done <= 1'b1;
          conv_data <= ch_val[last_ch];
        end
      end
    end
  end

  // =========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // fewest periodic starts: one rate period plus one converter pass each
  function automatic int min_starts(input int rate, input int cycles);
    return cycles / ((rate + 1) * STEP + CONV_CYC) - 1;
  endfunction : min_starts

  task automatic complete_run();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic wait_on(input bit po);
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      #1 if ((po ? poweroff_req : irq) === 1'b1) break;
    end
    if (k == 300) begin
      fail_count++;
      $display("FAIL t=%0t wait timed out", $time);
      complete_run();
    end
  endtask : wait_on

  task automatic set_slot(input int s, input logic [11:0] l, input logic pol);
    wr_reg(5'(OFS_SLOT_BASE + 4 * s + SLOT_LIM_HI), {pol, 3'h0, l[11:8]});
    wr_reg(5'(OFS_SLOT_BASE + 4 * s + SLOT_LIM_LO), l[7:0]);
  endtask : set_slot

  // =========================================================
  // main sequence
  initial begin
    {srst, wr, rd, addr, wdata} = {1'b1, 15'h0};
    {seed, fail_count, checked} = {32'h3c6d, 64'h0};
    for (i = 0; i < 16; i++) ch_val[i] = 12'h000;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 10; i++) begin
      rd_reg(i[4:0], d);
      chk(d, i == 2 ? RST_IRQ_MASK : i == 8 ? RST_POFF_DLY : i == 9 ? {4'h0, ACS_IDLE} : RST_ZERO);
    end
    wr_reg(5'h0c, 8'hff);
    rd_reg(5'h0c, d);
    chk(d, 8'h00);
    chk({7'h0, conv_power}, 8'h00);
    wr_reg(OFS_CONV_CTRL1, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, conv_power}, 8'h01);
    chk(converter_control_one, 8'h01);
    wr_reg(OFS_CONV_CTRL1, 8'h00);
    // oneshot: first pass masked, then corner and random values
    for (i = 0; i < 6; i++) begin
      r = rnd();
      ch = (i == 1) ? 4'h0 : r[15:12];
      ch_val[ch] = (i == 1) ? 12'hfff : (i == 2) ? 12'h000 : r[11:0];
      wr_reg(OFS_IRQ_MASK, (i == 0) ? 8'h03 : 8'h02);
      n = starts;
      wr_reg(OFS_ONESHOT_SEL, {4'h9, ch});
      if (i == 0) repeat (14) @(posedge clk);
      else wait_on(1'b0);
      #1 chk(8'(starts - n), 8'h01);
      chk({4'h0, last_ch}, {4'h0, ch});
      chk({7'h0, irq}, {7'h0, i != 0});
      rd_reg(OFS_IRQ_FLAGS, d);
      chk(d & 8'h01, 8'h01);
      rd_reg(OFS_OS_RES_HI, d);
      chk(d, {4'h0, ch_val[ch][11:8]});
      rd_reg(OFS_OS_RES_LO, d);
      chk(d, ch_val[ch][7:0]);
      rd_reg(OFS_ONESHOT_SEL, d);
      chk(d & 8'h10, 8'h00);
      chk({7'h0, conv_power}, 8'h00);
      wr_reg(OFS_IRQ_FLAGS, 8'h01);
      rd_reg(OFS_IRQ_FLAGS, d);
      chk(d & 8'h01, 8'h00);
    end
    // slot 0 above: equal stays quiet, one more crosses
    r = rnd();
    lim = {2'b01, r[9:0]};
    ch0 = r[19:16];
    ch1 = ~ch0;
    ch_val[ch0] = lim;
    wr_reg(OFS_IRQ_MASK, 8'h00);
    set_slot(0, lim, 1'b1);
    wr_reg(OFS_PER_SEL, {ch1, ch0});
    n = starts;
    wr_reg(OFS_PER_CTRL, {r[23:20], 4'h1});
    repeat (100) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    chk({7'h0, starts - n >= min_starts(r[23:20], 100)}, 8'h01);
    chk({4'h0, last_ch}, {4'h0, ch0});
    rd_reg(OFS_SLOT_BASE + 5'(SLOT_RES_HI), d);
    chk(d, {4'h0, lim[11:8]});
    rd_reg(OFS_SLOT_BASE + 5'(SLOT_RES_LO), d);
    chk(d, lim[7:0]);
    ch_val[ch0] = lim + 12'h001;
    wait_on(1'b0);
    rd_reg(OFS_IRQ_FLAGS, d);
    chk(d & 8'h02, 8'h02);
    wr_reg(OFS_PER_CTRL, 8'h00);
    repeat (20) @(posedge clk);
    wr_reg(OFS_IRQ_FLAGS, 8'h02);
    n = starts;
    repeat (60) @(posedge clk);
    #1 chk(8'(starts - n), 8'h00);
    chk({7'h0, irq}, 8'h00);
    // slot 1 below, masked then unmasked
    set_slot(1, lim, 1'b0);
    ch_val[ch1] = lim;
    wr_reg(OFS_PER_CTRL, 8'h02);
    repeat (60) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    rd_reg(OFS_SLOT_BASE + 5'h04 + 5'(SLOT_RES_LO), d);
    chk(d, lim[7:0]);
    wr_reg(OFS_IRQ_MASK, 8'h02);
    ch_val[ch1] = lim - 12'h001;
    repeat (60) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    rd_reg(OFS_IRQ_FLAGS, d);
    chk(d & 8'h02, 8'h02);
    wr_reg(OFS_IRQ_MASK, 8'h00);
    wait_on(1'b0);
    // poweroff: cancelled by clearing, then taken
    wr_reg(OFS_PER_CTRL, 8'h00);
    wr_reg(OFS_POFF_DLY, 8'h20);
    repeat (20) @(posedge clk);
    wr_reg(OFS_IRQ_FLAGS, 8'h03);
    wr_reg(OFS_PER_CTRL, 8'h0a);
    wait_on(1'b0);
    wr_reg(OFS_PER_CTRL, 8'h00);
    repeat (15) @(posedge clk);
    wr_reg(OFS_IRQ_FLAGS, 8'h02);
    repeat (100) @(posedge clk);
    #1 chk({7'h0, poweroff_req}, 8'h00);
    wr_reg(OFS_POFF_DLY, 8'h04);
    wr_reg(OFS_PER_CTRL, 8'h0a);
    wait_on(1'b1);
    chk({7'h0, poweroff_req}, 8'h01);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1 chk({6'h0, poweroff_req, irq}, 8'h00);
    complete_run();
  end
endmodule : acs_seq_tb

bind acs_seq acs_seq_props #(.POFF_STEP(POFF_STEP), .RATE_STEP(RATE_STEP)) u_props (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .conv_power(conv_power), .conv_start(conv_start), .conv_channel(conv_channel),
  .conv_done(conv_done), .conv_data(conv_data), .irq(irq), .poweroff_req(poweroff_req),
  .converter_control_one(converter_control_one));
